// File: dv/afe_host_model.sv
module afe_host_model (
	output logic shift_clock,
	output logic serial_in_line,
	output logic load_strobe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		shift_clock = 1'b0;
		serial_in_line = 1'b1;
		load_strobe_n = 1'b1;
	end

	// clock stands low outside frames except during stray, so idle edges reach the port only from stray
	task automatic send(input logic [11:0] word);
		load_strobe_n = 1'b0;
		#170;
		for (int i = 11; i >= 0; i--) begin
			serial_in_line = word[i];
			#160 shift_clock = 1'b1;
			#160 shift_clock = 1'b0;
		end
		#80 load_strobe_n = 1'b1;
		// released line must not keep showing the last bit
		serial_in_line = ~serial_in_line;
		#400;
	endtask

	// edges with the strobe high, only on the bench's command
	task automatic stray(input int unsigned n);
		for (int i = 0; i < n; i++) begin
			serial_in_line = ~serial_in_line;
			#160 shift_clock = 1'b1;
			#160 shift_clock = 1'b0;
		end
	endtask
endmodule // afe_host_model

// File: dv/ccd_front_end_serial_config_bench.sv
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
	miscompares++; $display("Error t=%0t got %h exp %h", $time, got, exp); \
	end end

module ccd_front_end_serial_config_bench;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [3:0]             addr;
		afe_cfg_pkg::settings_t st;
	} note_t;

	logic                   ref_clk;
	logic                   arst_n;
	logic                   clk_en;
	logic                   shift_clock;
	logic                   serial_in_line;
	logic                   load_strobe_n;
	afe_cfg_pkg::settings_t settings;
	afe_cfg_pkg::settings_t model;
	afe_cfg_pkg::settings_t dflt;
	logic                   write_pulse;
	logic [3:0]             write_addr;
	note_t                  exp_q[$];
	int                     miscompares = 0;
	int                     total_checks = 0;

	assign dflt = afe_cfg_pkg::settings_t'({afe_cfg_pkg::rst_gain,
		afe_cfg_pkg::rst_target, afe_cfg_pkg::rst_delay,
		afe_cfg_pkg::rst_clock, afe_cfg_pkg::rst_control,
		afe_cfg_pkg::rst_calibration, afe_cfg_pkg::rst_fine,
		afe_cfg_pkg::rst_coarse});

	afe_host_model u_afe_host_model (
		.shift_clock   (shift_clock),
		.serial_in_line(serial_in_line),
		.load_strobe_n (load_strobe_n)
	);

	afe_serial_config u_afe_serial_config (
		.ref_clk       (ref_clk),
		.arst_n        (arst_n),
		.clk_en        (clk_en),
		.shift_clock   (shift_clock),
		.serial_in_line(serial_in_line),
		.load_strobe_n (load_strobe_n),
		.settings      (settings),
		.write_pulse   (write_pulse),
		.write_addr    (write_addr)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// keeps host-side data within the allowed codes
	function automatic logic [7:0] legal(logic [3:0] a, logic [7:0] d);
		if (a == afe_cfg_pkg::addr_target && d[5:0] < 6'h02)
			d[5:0] = 6'h20;
		if (a == afe_cfg_pkg::addr_delay)
			d[1:0] = 2'b00;
		if (a == afe_cfg_pkg::addr_clock)
			d[5] = 1'b0;
		return d;
	endfunction

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		case (a)
			4'h0: model.gain = d;
			4'h1: model.target_offset = d[5:0];
			4'h2: model.delay = d;
			4'h3: model.clock_pol = d[6:0];
			4'h4: model.control = d[3:0];
			4'h5: model.calib = d[4:0];
			4'h6: model.fine_trim_level[9:2] = d;
			4'h7: model.fine_trim_level[1:0] = d[1:0];
			4'h8: model.coarse_trim_level = d[3:0];
			4'hf: if (d[0]) model = dflt;
			default: ;
		endcase
		if (!(a inside {[4'h9:4'he]}))
			exp_q.push_back('{a, model});
		u_afe_host_model.send({a, d});
	endtask

	task automatic do_reset();
		@(posedge ref_clk) arst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		arst_n <= 1'b1;
		model = dflt;
		repeat (4) @(posedge ref_clk);
		#1 `CHK(settings, dflt)
	endtask

	task automatic finish_test();
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// result watcher: each commit pulse outside addresses 9h-Eh is matched to the oldest note; those are checked against model
	initial begin : watch
		logic [3:0] a;
		note_t      e;
		forever begin
			@(posedge ref_clk);
			#1;
			if (write_pulse === 1'b1) begin
				a = write_addr;
				repeat (2) @(posedge ref_clk);
				#1;
				if (a inside {[4'h9:4'he]}) begin
					`CHK(settings, model)
				end else if (exp_q.size() == 0) begin
					`CHK(a, 4'hx)
				end else begin
					e = exp_q.pop_front();
					`CHK(a, e.addr)
					`CHK(settings, e.st)
				end
			end
		end
	end

	initial begin
		#1000000;
		miscompares++;
		finish_test();
	end

	initial begin : main
		logic [3:0] regs [10];
		regs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
		arst_n = 1'b0;
		clk_en = 1'b1;
		model = dflt;
		void'($urandom(23710));
		do_reset();
		wr(afe_cfg_pkg::addr_soft_reset, 8'h01);
		for (int k = 0; k < 3; k++)
			foreach (regs[i]) wr(regs[i], legal(regs[i], 8'($urandom)));
		u_afe_host_model.stray(5);
		@(posedge ref_clk) clk_en <= 1'b0;
		repeat (4) @(posedge ref_clk);
		clk_en <= 1'b1;
		#401 `CHK(settings, model)
		for (int a = 9; a < 15; a++)
			wr(4'(a), 8'($urandom));
		wr(afe_cfg_pkg::addr_control, 8'h02);
		wr(afe_cfg_pkg::addr_soft_reset, 8'h00);
		wr(afe_cfg_pkg::addr_fine_upper, 8'h80);
		wr(afe_cfg_pkg::addr_fine_lower, 8'h03);
		wr(afe_cfg_pkg::addr_soft_reset, 8'h01);
		wr(afe_cfg_pkg::addr_gain, 8'hff);
		do_reset();
		wr(afe_cfg_pkg::addr_coarse, 8'hfb);
		#400 `CHK(exp_q.size(), 0)
		finish_test();
	end
endmodule // ccd_front_end_serial_config_bench

// File: hw/afe_cfg_pkg.sv
package afe_cfg_pkg;
	localparam int unsigned word_bits = 12;
	localparam int unsigned addr_bits = 4;
	localparam int unsigned data_bits = 8;
	localparam int unsigned reg_count = 16;

	localparam logic [3:0] addr_gain         = 4'h0;
	localparam logic [3:0] addr_target       = 4'h1;
	localparam logic [3:0] addr_delay        = 4'h2;
	localparam logic [3:0] addr_clock        = 4'h3;
	localparam logic [3:0] addr_control     = 4'h4;
	localparam logic [3:0] addr_calibration  = 4'h5;
	localparam logic [3:0] addr_fine_upper   = 4'h6;
	localparam logic [3:0] addr_fine_lower   = 4'h7;
	localparam logic [3:0] addr_coarse       = 4'h8;
	localparam logic [3:0] addr_soft_reset   = 4'hf;

	// defaults after power-up or soft reset
	localparam logic [7:0] rst_gain        = 8'h00;
	localparam logic [5:0] rst_target      = 6'h20;
	localparam logic [7:0] rst_delay       = 8'h00;
	localparam logic [6:0] rst_clock       = 7'h10;
	localparam logic [3:0] rst_control     = 4'h1;
	localparam logic [4:0] rst_calibration = 5'h0c;
	localparam logic [9:0] rst_fine        = 10'h000;
	localparam logic [3:0] rst_coarse      = 4'h0;

	// field positions
	localparam int unsigned pos_black_delay = 5;
	localparam int unsigned pos_video_delay = 2;
	localparam int unsigned pos_soft_reset  = 0;

	typedef struct packed {
		logic [2:0] black_delay;
		logic [2:0] video_delay;
		logic [1:0] delay_test_bits;
	} delay_t;

	typedef struct packed {
		logic reset_noise_clocked;
		logic clock_test;
		logic both_clamps;
		logic black_sample_high;
		logic video_sample_high;
		logic restore_clamp_high;
		logic black_clamp_high;
	} clock_pol_t;

	typedef struct packed {
		logic delay_test;
		logic converter_input_test;
		logic power_down;
		logic output_enable;
	} control_t;

	typedef struct packed {
		logic cal_hold;
		logic fast_settle;
		logic smoothing_select;
		logic narrow_range;
		logic manual_trim;
	} calib_t;

	typedef struct packed {
		logic [7:0]  gain;
		logic [5:0]  target_offset;
		delay_t      delay;
		clock_pol_t  clock_pol;
		control_t    control;
		calib_t      calib;
		logic [9:0]  fine_trim_level;
		logic [3:0]  coarse_trim_level;
	} settings_t;

	typedef enum logic [1:0] {
		st_idle  = 2'b00,
		st_shift = 2'b01,
		st_commit = 2'b10
	} port_state_t;
endpackage

// File: hw/afe_serial_config.sv
// Functional notes
// - word is 4 address plus 8 data
// - address then data, msb first
// - shift only while load is low
// - load rising edge commits data to register
// - undefined address discards data
// - no readback, no address check
// - fixed 4-bit register address decode
// - target offset 6 bits, default 20h
// - delay fields 7:5 and 4:2
// - clock register mode and clamp bits
// - clock bits 3:0 set polarities
// - control: test, power down, outputs
// - calibration register five control bits
// - defaults on reset; power down keeps
// - fine trim 10 bits over two addresses
// - reset bit 0 set to 1 restores all defaults
module afe_serial_config (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 clk_en,
	input  wire logic                 shift_clock,
	input  wire logic                 serial_in_line,
	input  wire logic                 load_strobe_n,
	output afe_cfg_pkg::settings_t    settings,
	output logic                      write_pulse,
	output logic [3:0]                write_addr
);
	logic [2:0]  sync_bits;
	logic        sclk_s;
	logic        data_in_s;
	logic        load_n_s;
	logic        sclk_d;
	logic        load_n_d;
	logic [11:0] shift_word;
	logic [3:0]  bit_count;
	logic        soft_reset;
	afe_cfg_pkg::port_state_t state;
	afe_cfg_pkg::port_state_t next_state;

	// strobe enters inverted: a cleared synchroniser then reads as idle
	bit_sync #(
		.width(3)
	) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.clk_en  (clk_en),
		.async_in({shift_clock, serial_in_line, ~load_strobe_n}),
		.sync_out(sync_bits)
	);

	assign sclk_s    = sync_bits[2];
	assign data_in_s = sync_bits[1];
	assign load_n_s  = ~sync_bits[0];

	wire sclk_rise = sclk_s && !sclk_d;
	wire load_rise = load_n_s && !load_n_d;
	wire [3:0] cmd_addr = shift_word[11:8];
	wire [7:0] cmd_data = shift_word[7:0];

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_d   <= 1'b0;
			load_n_d <= 1'b1;
		end else if (clk_en) begin
			sclk_d   <= sclk_s;
			load_n_d <= load_n_s;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			afe_cfg_pkg::st_idle:
				if (!load_n_s)
					next_state = afe_cfg_pkg::st_shift;
			afe_cfg_pkg::st_shift:
				if (load_rise)
					next_state = afe_cfg_pkg::st_commit;
			afe_cfg_pkg::st_commit:
				next_state = afe_cfg_pkg::st_idle;
			default:
				next_state = afe_cfg_pkg::st_idle;
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			state <= afe_cfg_pkg::st_idle;
		else if (clk_en)
			state <= next_state;
	end

	// shift register: msb-first, toward the top end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_word <= 12'h000;
			bit_count  <= 4'h0;
		end else if (clk_en) begin
			if (load_n_s) begin
				bit_count <= 4'h0;
			end else if (sclk_rise) begin
				shift_word <= {shift_word[10:0], data_in_s};
				if (bit_count != 4'hf)
					bit_count <= bit_count + 4'h1;
			end
		end
	end

	// commit on load rise; address decides the target
	wire commit = (state == afe_cfg_pkg::st_shift) && load_rise;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			write_pulse <= 1'b0;
			write_addr  <= 4'h0;
			soft_reset  <= 1'b0;
		end else if (clk_en) begin
			write_pulse <= commit;
			if (commit)
				write_addr <= cmd_addr;
			soft_reset <= commit && cmd_addr == afe_cfg_pkg::addr_soft_reset
				&& cmd_data[afe_cfg_pkg::pos_soft_reset];
		end
	end

	// register bank; write-only, nothing reads it back over the port
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			settings.gain              <= afe_cfg_pkg::rst_gain;
			settings.target_offset     <= afe_cfg_pkg::rst_target;
			settings.delay             <= afe_cfg_pkg::rst_delay;
			settings.clock_pol         <= afe_cfg_pkg::rst_clock;
			settings.control           <= afe_cfg_pkg::rst_control;
			settings.calib             <= afe_cfg_pkg::rst_calibration;
			settings.fine_trim_level   <= afe_cfg_pkg::rst_fine;
			settings.coarse_trim_level <= afe_cfg_pkg::rst_coarse;
		end else if (clk_en) begin
			if (soft_reset) begin
				settings.gain              <= afe_cfg_pkg::rst_gain;
				settings.target_offset     <= afe_cfg_pkg::rst_target;
				settings.delay             <= afe_cfg_pkg::rst_delay;
				settings.clock_pol         <= afe_cfg_pkg::rst_clock;
				settings.control           <= afe_cfg_pkg::rst_control;
				settings.calib             <= afe_cfg_pkg::rst_calibration;
				settings.fine_trim_level   <= afe_cfg_pkg::rst_fine;
				settings.coarse_trim_level <= afe_cfg_pkg::rst_coarse;
			end else if (commit) begin
				case (cmd_addr)
					afe_cfg_pkg::addr_gain:
						settings.gain <= cmd_data;
					afe_cfg_pkg::addr_target:
						settings.target_offset <= cmd_data[5:0];
					afe_cfg_pkg::addr_delay:
						settings.delay <= cmd_data;
					afe_cfg_pkg::addr_clock:
						settings.clock_pol <= cmd_data[6:0];
					afe_cfg_pkg::addr_control:
						settings.control <= cmd_data[3:0];
					afe_cfg_pkg::addr_calibration:
						settings.calib <= cmd_data[4:0];
					afe_cfg_pkg::addr_fine_upper:
						settings.fine_trim_level[9:2] <= cmd_data;
					afe_cfg_pkg::addr_fine_lower:
						settings.fine_trim_level[1:0] <= cmd_data[1:0];
					afe_cfg_pkg::addr_coarse:
						settings.coarse_trim_level <= cmd_data[3:0];
					default: ;
				endcase
			end
		end
	end

	// power down is only a stored bit; it never reloads defaults

	chk_commit_pulse: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit
		|=> write_pulse && write_addr == $past(cmd_addr))
		else $error("commit not reported");

	chk_pulse_cause: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && !commit |=> !write_pulse)
		else $error("write pulse without a commit");

	chk_pulse_single: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && write_pulse |=> !write_pulse)
		else $error("write pulse longer than one cycle");

	chk_gain_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_gain
		&& !soft_reset
		|=> settings.gain == $past(cmd_data))
		else $error("gain not written");

	chk_target_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_target
		&& !soft_reset
		|=> settings.target_offset == $past(cmd_data[5:0]))
		else $error("target offset not written");

	chk_delay_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_delay
		&& !soft_reset
		|=> settings.delay == $past(cmd_data))
		else $error("delay not written");

	chk_clock_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_clock
		&& !soft_reset
		|=> settings.clock_pol == $past(cmd_data[6:0]))
		else $error("clock register not written");

	chk_polarity_bits: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_clock
		&& !soft_reset
		|=> {settings.clock_pol.black_sample_high,
		settings.clock_pol.video_sample_high,
		settings.clock_pol.restore_clamp_high,
		settings.clock_pol.black_clamp_high} == $past(cmd_data[3:0]))
		else $error("polarity bits out of place");

	chk_control_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_control
		&& !soft_reset
		|=> settings.control == $past(cmd_data[3:0]))
		else $error("control not written");

	chk_calib_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_calibration
		&& !soft_reset
		|=> settings.calib == $past(cmd_data[4:0]))
		else $error("calibration not written");

	chk_fine_upper: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_fine_upper
		&& !soft_reset
		|=> settings.fine_trim_level[9:2] == $past(cmd_data))
		else $error("fine upper not written");

	chk_fine_split: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_fine_lower
		&& !soft_reset
		|=> settings.fine_trim_level[9:2]
		== $past(settings.fine_trim_level[9:2]))
		else $error("fine lower touched upper");

	chk_coarse_write: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_coarse
		&& !soft_reset
		|=> settings.coarse_trim_level == $past(cmd_data[3:0]))
		else $error("coarse trim not written");

	chk_undef_keep: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr inside {[4'h9:4'he]}
		&& !soft_reset |=> $stable(settings))
		else $error("undefined address changed settings");

	chk_soft_request: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_soft_reset
		&& cmd_data[afe_cfg_pkg::pos_soft_reset] |=> soft_reset)
		else $error("soft reset request lost");

	chk_soft_normal: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_soft_reset
		&& !cmd_data[afe_cfg_pkg::pos_soft_reset] && !soft_reset
		|=> !soft_reset && $stable(settings))
		else $error("soft reset word of zero changed settings");

	chk_soft_defaults: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && soft_reset
		|=> settings.gain == afe_cfg_pkg::rst_gain
		&& settings.target_offset == afe_cfg_pkg::rst_target
		&& settings.delay == afe_cfg_pkg::rst_delay
		&& settings.clock_pol == afe_cfg_pkg::rst_clock
		&& settings.control == afe_cfg_pkg::rst_control
		&& settings.calib == afe_cfg_pkg::rst_calibration
		&& settings.fine_trim_level == afe_cfg_pkg::rst_fine
		&& settings.coarse_trim_level == afe_cfg_pkg::rst_coarse)
		else $error("soft reset missed defaults");

	chk_powerdown_keeps: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && commit && cmd_addr == afe_cfg_pkg::addr_control
		&& cmd_data[1] && !soft_reset
		|=> $stable(settings.gain) && $stable(settings.fine_trim_level))
		else $error("power down changed other settings");

	chk_shift_hold: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && load_n_s |=> $stable(shift_word))
		else $error("shifted while load high");

	chk_shift_msb: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && !load_n_s && sclk_rise
		|=> shift_word == {$past(shift_word[10:0]), $past(data_in_s)})
		else $error("bit order wrong");

	chk_count_clear: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && load_n_s |=> bit_count == 4'h0)
		else $error("bit count not cleared while load high");

	chk_count_step: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		clk_en && !load_n_s && sclk_rise && bit_count != 4'hf
		|=> bit_count == $past(bit_count) + 4'h1)
		else $error("bit count did not advance");

	chk_enable_freeze: assert property (@(posedge ref_clk)
		disable iff (!arst_n)
		!clk_en |=> $stable(settings) && $stable(shift_word)
		&& $stable(state) && $stable(write_pulse))
		else $error("state moved while clock enable low");
endmodule // afe_serial_config

// File: hw/bit_sync.sv
module bit_sync #(
	parameter int unsigned width = 3
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             clk_en,
	input  wire logic [width-1:0] async_in,
	output logic      [width-1:0] sync_out
);
	logic [width-1:0] stage1;

	// stage1 feeds only stage2
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			stage1   <= '0;
			sync_out <= '0;
		end else if (clk_en) begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // bit_sync
